// file: wdt_counter.sv
// Watchdog up-counter with a selectable terminal count.
// Assumes tick_in is a one-cycle enable, one per watchdog clock edge.
`timescale 1ns/10ps
module wdt_counter
    import wdt_pkg::*;
#(
    parameter int unsigned CNT_W = WDT_CNT_W
) (
    input  wire logic             clk_in,   // System clock.
    input  wire logic             rst_in,   // Synchronous reset, active high.
    input  wire logic             clear_in, // Clear to zero, wins over a tick.
    input  wire logic             tick_in,  // Count enable pulse.
    input  wire logic [2:0]       sel_in,   // Overflow limit select.
    output logic      [CNT_W-1:0] count_out,// Present count.
    output logic                  ovf_out   // Limit reached on this tick.
);

    initial begin
        if (CNT_W != WDT_CNT_W) begin
            $error("wdt_counter: counter width must be 17");
        end
    end

    logic [CNT_W-1:0] count_q, count_d;

    // Last count before the limit; the limit itself may equal 2^17.
    function automatic logic [CNT_W-1:0] last_count(input logic [2:0] sel);
        logic [17:0] limit;
        limit = WDT_LIMIT_BASE << sel;
        return CNT_W'(limit - 18'h00001);
    endfunction

    assign ovf_out = tick_in & ~clear_in & (count_q == last_count(sel_in));

    always_comb begin
        count_d = count_q;
        if (clear_in || ovf_out) begin
            count_d = '0;
        end else if (tick_in) begin
            count_d = count_q + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    assign count_out = count_q;

endmodule

// file: wdt_edge_sync.sv
// Two-flop synchroniser for an asynchronous pin, with a rise detector.
// Assumes the pin toggles slower than half the system clock.
`timescale 1ns/10ps
module wdt_edge_sync (
    input  wire logic clk_in,    // System clock.
    input  wire logic rst_in,    // Synchronous reset, active high.
    input  wire logic async_in,  // Asynchronous pin level.
    output logic      level_out, // Synchronised level.
    output logic      rise_out   // One-cycle pulse on a rising edge.
);

    logic meta_q, meta_d;
    logic sync_q, sync_d;
    logic prev_q, prev_d;

    // The first flop feeds only the second; the detector looks at later stages.
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    assign level_out = sync_q;
    assign rise_out  = sync_q & ~prev_q;

endmodule

// file: wdt_pkg.sv
// Constants shared by the watchdog timer files: register indices, field
// positions, reset values and bus answer codes.
// Assumes the watchdog is reached over a 32-bit AXI4-Lite slave port.
package wdt_pkg;

    // =========================================================================
    // Register map (indices; byte address is four times the index)
    // =========================================================================
    localparam int unsigned WDT_ADDR_W       = 18;
    localparam logic [15:0] WDT_CTRL_IDX     = 16'hFE79;
    localparam logic [15:0] WDT_SERVICE_IDX  = 16'hFE7A;
    localparam logic [15:0] WDT_OSC_IDX      = 16'hFE7B;

    // =========================================================================
    // Control register fields
    // =========================================================================
    localparam int unsigned WDT_RSTF_BIT     = 7;
    localparam int unsigned WDT_CKSL_BIT     = 6;
    localparam int unsigned WDT_RUN_BIT      = 5;
    localparam int unsigned WDT_IDL_HI_BIT   = 4;
    localparam int unsigned WDT_IDL_LO_BIT   = 3;
    localparam int unsigned WDT_SEL_MSB      = 2;
    localparam logic [7:0]  WDT_CTRL_RESET   = 8'h00;
    // Bits kept across a watchdog-triggered reset: bit 6 and bits 4 to 0.
    localparam logic [7:0]  WDT_KEEP_MASK    = 8'h5F;
    localparam logic [7:0]  WDT_SERVICE_KEY  = 8'h55;

    // Oscillator control fields held locally.
    localparam int unsigned WDT_RC_START_BIT = 0;
    localparam int unsigned WDT_SUB_EN_BIT   = 6;
    localparam logic [7:0]  WDT_OSC_RESET    = 8'h00;
    localparam logic [7:0]  WDT_OSC_MASK     = 8'h41;

    // =========================================================================
    // Counter and standby codes
    // =========================================================================
    localparam int unsigned WDT_CNT_W        = 17;
    localparam logic [17:0] WDT_LIMIT_BASE   = 18'h00400;
    localparam logic [1:0]  WDT_STBY_SUSPEND = 2'h1;
    localparam logic [1:0]  WDT_STBY_RETAIN  = 2'h2;

    // =========================================================================
    // AXI4-Lite answers
    // =========================================================================
    localparam logic [1:0]  WDT_RESP_OKAY    = 2'h0;
    localparam logic [1:0]  WDT_RESP_SLVERR  = 2'h2;

endpackage

// file: wdt_timer.sv
// Watchdog timer top: AXI4-Lite register slave, clock selection,
// standby handling, subclock failure watch and reset generation.
// Assumes the two watchdog clocks and the reset pin are asynchronous pins
// sampled here; standby and hold flags come from logic on clk_in.
`timescale 1ns/10ps

// How it works
// - 17-bit counter counts selected watchdog clock edges.
// - Bit 6 picks RC or subclock.
// - Three select bits choose 1024..131072 limit.
// - Overflow resets, clears run, sets flag.
// - Run bit starts or stops counting.
// - Control writes ignored while running.
// - Service write of 55H clears counter.
// - Two bits choose standby behaviour.
// - Counter held clear while stopped.
// - Pin or power reset zeroes control.
// - Flag cleared by resets, set, writable.
// - RC request ORed with oscillator start bit.
// - RC request not cancelled by oscillator register.
// - Subclock stop while running on subclock forces reset.
// - Suspend code clears run at standby.
// - Retain code freezes count during standby.
module wdt_timer
    import wdt_pkg::*;
(
    input  wire logic        clk_in,                 // System clock, 250 MHz.
    input  wire logic        rst_in,                 // Power-on or low-voltage reset.
    input  wire logic        external_reset_pin_n_in,// Reset pin, active low, async.
    input  wire logic        lowspeed_rc_clk_in,     // Low-speed RC clock, async.
    input  wire logic        subclock_in,            // Subclock, async.
    input  wire logic        standby_in,             // CPU in HALT or HOLD.
    input  wire logic        hold_in,                // CPU in HOLD.
    input  wire logic [17:0] s_axi_awaddr,           // Write address.
    input  wire logic        s_axi_awvalid,          // Write address valid.
    output logic             s_axi_awready,          // Write address ready.
    input  wire logic [31:0] s_axi_wdata,            // Write data.
    input  wire logic [3:0]  s_axi_wstrb,            // Write strobes.
    input  wire logic        s_axi_wvalid,           // Write data valid.
    output logic             s_axi_wready,           // Write data ready.
    output logic [1:0]       s_axi_bresp,            // Write response.
    output logic             s_axi_bvalid,           // Write response valid.
    input  wire logic        s_axi_bready,           // Write response ready.
    input  wire logic [17:0] s_axi_araddr,           // Read address.
    input  wire logic        s_axi_arvalid,          // Read address valid.
    output logic             s_axi_arready,          // Read address ready.
    output logic [31:0]      s_axi_rdata,            // Read data.
    output logic [1:0]       s_axi_rresp,            // Read response.
    output logic             s_axi_rvalid,           // Read data valid.
    input  wire logic        s_axi_rready,           // Read data ready.
    output logic             wdt_reset_out,          // Watchdog reset pulse.
    output logic             rc_osc_request_out      // Low-speed RC run request.
);

    // =========================================================================
    // Pin synchronisers
    // =========================================================================
    logic rc_rise;
    logic sub_rise;
    logic pin_level;

    wdt_edge_sync u_rc_sync (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .async_in  (lowspeed_rc_clk_in),
        .level_out (),
        .rise_out  (rc_rise)
    );

    wdt_edge_sync u_sub_sync (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .async_in  (subclock_in),
        .level_out (),
        .rise_out  (sub_rise)
    );

    wdt_edge_sync u_pin_sync (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .async_in  (external_reset_pin_n_in),
        .level_out (pin_level),
        .rise_out  ()
    );

    logic pin_reset;
    assign pin_reset = ~pin_level;

    // =========================================================================
    // Bus decode helpers
    // =========================================================================
    function automatic logic hits(input logic [17:0] addr, input logic [15:0] idx);
        return addr[17:2] == idx;
    endfunction

    function automatic logic mapped(input logic [17:0] addr);
        return hits(addr, WDT_CTRL_IDX) | hits(addr, WDT_SERVICE_IDX)
             | hits(addr, WDT_OSC_IDX);
    endfunction

    // =========================================================================
    // AXI4-Lite write channel
    // =========================================================================
    logic        aw_full_q, aw_full_d;
    logic [17:0] aw_addr_q, aw_addr_d;
    logic        w_full_q, w_full_d;
    logic [7:0]  w_data_q, w_data_d;
    logic        w_lane_q, w_lane_d;
    logic        awready_q, awready_d;
    logic        wready_q, wready_d;
    logic        bvalid_q, bvalid_d;
    logic [1:0]  bresp_q, bresp_d;
    logic        wr_fire;

    // Address and data are taken in either order; the write fires once both
    // are held and no earlier response is still waiting.
    assign wr_fire = aw_full_q & w_full_q & ~bvalid_q;

    always_comb begin
        aw_full_d = aw_full_q;
        aw_addr_d = aw_addr_q;
        w_full_d  = w_full_q;
        w_data_d  = w_data_q;
        w_lane_d  = w_lane_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        if (s_axi_awvalid && awready_q) begin
            aw_full_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_full_d = 1'b1;
            w_data_d = s_axi_wdata[7:0];
            w_lane_d = s_axi_wstrb[0];
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (wr_fire) begin
            aw_full_d = 1'b0;
            w_full_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = mapped(aw_addr_q) ? WDT_RESP_OKAY : WDT_RESP_SLVERR;
        end
        awready_d = ~aw_full_d;
        wready_d  = ~w_full_d;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= '0;
            w_full_q  <= 1'b0;
            w_data_q  <= 8'h00;
            w_lane_q  <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= WDT_RESP_OKAY;
        end else begin
            aw_full_q <= aw_full_d;
            aw_addr_q <= aw_addr_d;
            w_full_q  <= w_full_d;
            w_data_q  <= w_data_d;
            w_lane_q  <= w_lane_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
        end
    end

    // Byte lane 0 must be strobed for a register to change.
    logic wr_ctrl;
    logic wr_service;
    logic wr_osc;
    assign wr_ctrl    = wr_fire & w_lane_q & hits(aw_addr_q, WDT_CTRL_IDX);
    assign wr_service = wr_fire & w_lane_q & hits(aw_addr_q, WDT_SERVICE_IDX);
    assign wr_osc     = wr_fire & w_lane_q & hits(aw_addr_q, WDT_OSC_IDX);

    // =========================================================================
    // Watchdog control state
    // =========================================================================
    logic [7:0]  ctrl_q, ctrl_d;
    logic [7:0]  osc_q, osc_d;
    logic        stby_prev_q, stby_prev_d;
    logic        wdt_rst_q, wdt_rst_d;
    logic        rc_req_q, rc_req_d;
    logic        running;
    logic        use_sub;
    logic [1:0]  stby_code;
    logic        retain_now;
    logic        sub_fail;
    logic        ovf;
    logic        trip;
    logic        cnt_clear;
    logic        cnt_tick;
    logic [16:0] count;

    assign running   = ctrl_q[WDT_RUN_BIT];
    assign use_sub   = ctrl_q[WDT_CKSL_BIT];
    assign stby_code = ctrl_q[WDT_IDL_HI_BIT:WDT_IDL_LO_BIT];

    assign retain_now = standby_in & (stby_code == WDT_STBY_RETAIN);

    assign sub_fail = running & use_sub & (~osc_q[WDT_SUB_EN_BIT] | hold_in);

    assign cnt_tick = running & ~retain_now & (use_sub ? sub_rise : rc_rise);

    // Dedicated service clear; cleared while stopped.
    assign cnt_clear = ~running | (wr_service & (w_data_q == WDT_SERVICE_KEY));

    wdt_counter #(
        .CNT_W (WDT_CNT_W)
    ) u_counter (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .clear_in  (cnt_clear),
        .tick_in   (cnt_tick),
        .sel_in    (ctrl_q[WDT_SEL_MSB:0]),
        .count_out (count),
        .ovf_out   (ovf)
    );

    assign trip = ovf | sub_fail;

    // Control register update. Priority: pin reset, watchdog trip, standby,
    // then software. A trip sets the flag even if software clears it in the
    // same cycle, so only a pin or power reset in that cycle leaves a trip unrecorded.
    always_comb begin
        ctrl_d      = ctrl_q;
        osc_d       = osc_q;
        stby_prev_d = standby_in;
        wdt_rst_d   = 1'b0;
        if (wr_osc) begin
            osc_d = w_data_q & WDT_OSC_MASK;
        end
        // Software write can start only; locked while running.
        if (wr_ctrl && !running) begin
            ctrl_d = w_data_q;
        end
        if (standby_in && !stby_prev_q && running
                && stby_code == WDT_STBY_SUSPEND) begin
            ctrl_d[WDT_RUN_BIT] = 1'b0;
        end
        if (trip) begin
            ctrl_d                = ctrl_q & WDT_KEEP_MASK;
            ctrl_d[WDT_RSTF_BIT]  = 1'b1;
            wdt_rst_d             = 1'b1;
        end
        // Pin reset zeroes control; also clears the flag.
        if (pin_reset) begin
            ctrl_d    = WDT_CTRL_RESET;
            wdt_rst_d = 1'b0;
        end
    end

    // RC request ORed; software start bit cannot cancel it.
    always_comb begin
        rc_req_d = (ctrl_d[WDT_RUN_BIT] & ~ctrl_d[WDT_CKSL_BIT] & ~retain_now)
                 | osc_d[WDT_RC_START_BIT];
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ctrl_q      <= WDT_CTRL_RESET;
            osc_q       <= WDT_OSC_RESET;
            stby_prev_q <= 1'b0;
            wdt_rst_q   <= 1'b0;
            rc_req_q    <= 1'b0;
        end else begin
            ctrl_q      <= ctrl_d;
            osc_q       <= osc_d;
            stby_prev_q <= stby_prev_d;
            wdt_rst_q   <= wdt_rst_d;
            rc_req_q    <= rc_req_d;
        end
    end

    // =========================================================================
    // AXI4-Lite read channel
    // =========================================================================
    logic        arready_q, arready_d;
    logic        rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0]  rresp_q, rresp_d;

    // One read at a time: the address is taken only while no data waits.
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d  = mapped(s_axi_araddr) ? WDT_RESP_OKAY : WDT_RESP_SLVERR;
            rdata_d  = 32'h00000000;
            if (hits(s_axi_araddr, WDT_CTRL_IDX)) begin
                rdata_d = {24'h000000, ctrl_q};
            end else if (hits(s_axi_araddr, WDT_OSC_IDX)) begin
                rdata_d = {24'h000000, osc_q};
            end
        end
        arready_d = ~rvalid_d & ~(s_axi_arvalid & arready_q);
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h00000000;
            rresp_q   <= WDT_RESP_OKAY;
        end else begin
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    // =========================================================================
    // Outputs, all straight from flops
    // =========================================================================
    assign s_axi_awready      = awready_q;
    assign s_axi_wready       = wready_q;
    assign s_axi_bvalid       = bvalid_q;
    assign s_axi_bresp        = bresp_q;
    assign s_axi_arready      = arready_q;
    assign s_axi_rvalid       = rvalid_q;
    assign s_axi_rdata        = rdata_q;
    assign s_axi_rresp        = rresp_q;
    assign wdt_reset_out      = wdt_rst_q;
    assign rc_osc_request_out = rc_req_q;

endmodule

// file: wdt_timer_monitor.sv
// Concurrent checks on the watchdog timer's ports.
// Assumes it is bound to wdt_timer and sees its clock and sync reset.
`timescale 1ns/10ps
module wdt_timer_chk (
    input  wire logic        clk_in,                  // System clock.
    input  wire logic        rst_in,                  // Sync reset, active high.
    input  wire logic        external_reset_pin_n_in, // Reset pin, active low.
    input  wire logic        s_axi_awvalid,           // Write address valid.
    input  wire logic        s_axi_awready,           // Write address ready.
    input  wire logic        s_axi_wvalid,            // Write data valid.
    input  wire logic        s_axi_wready,            // Write data ready.
    input  wire logic [1:0]  s_axi_bresp,             // Write response.
    input  wire logic        s_axi_bvalid,            // Write response valid.
    input  wire logic        s_axi_bready,            // Write response ready.
    input  wire logic        s_axi_arvalid,           // Read address valid.
    input  wire logic        s_axi_arready,           // Read address ready.
    input  wire logic [31:0] s_axi_rdata,             // Read data.
    input  wire logic        s_axi_rvalid,            // Read data valid.
    input  wire logic        s_axi_rready,            // Read data ready.
    input  wire logic        wdt_reset_out            // Watchdog reset pulse.
);
    // =========================================================================
    // Checks, all in the system clock domain
    // =========================================================================
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // A trip is a single-cycle pulse, so the CPU reset logic sees one event.
    a_trip_one_pulse: assert property (wdt_reset_out |=> !wdt_reset_out)
        else $error("watchdog reset wider than one cycle");
    // A held pin reset wipes the control bits, so nothing may trip.
    a_pin_no_trip: assert property (!external_reset_pin_n_in [*5] |-> !wdt_reset_out)
        else $error("watchdog reset during pin reset");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write response late");
    a_aw_drop_ready: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("awready stayed high after handshake");
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed while waiting");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    a_ar_busy_low: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready high while read pending");

    // Main scenarios reached.
    c_trip: cover property (wdt_reset_out);
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

// file: wdt_timer_tb_top.sv
// Self-checking bench for the watchdog timer over its AXI4-Lite port.
// Assumes the register indices of wdt_pkg; RC clock is made slow and async.
`timescale 1ns/10ps
module wdt_timer_tb_top
    import wdt_pkg::*;
;
    logic clk_in = 0, rst_in = 1, external_reset_pin_n_in = 1, lowspeed_rc_clk_in = 0;
    logic subclock_in = 0, standby_in = 0, hold_in = 0;
    logic [17:0] s_axi_awaddr = 18'h00000, s_axi_araddr = 18'h00000;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, wdt_reset_out, rc_osc_request_out;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int n_mismatch = 0, tests_run = 0, n_pulse = 0;

    // =========================================================================
    // Clock, design and trip counter
    // =========================================================================
    always #2 clk_in = ~clk_in;
    wdt_timer u_dut (.clk_in, .rst_in, .external_reset_pin_n_in, .lowspeed_rc_clk_in,
        .subclock_in, .standby_in, .hold_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wdt_reset_out, .rc_osc_request_out);
    // Count every trip pulse seen at the port.
    always @(posedge clk_in) if (wdt_reset_out === 1'b1) n_pulse++;

    // =========================================================================
    // Tasks
    // =========================================================================
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // A wait that runs out is a mismatch and closes the run.
    task automatic give_up();
        n_mismatch++;
        $display("[FAIL] %0t bus handshake timed out", $time);
        results();
    endtask
    // Write address and data are offered together and each dropped when taken.
    task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
        int k;
        logic got;
        got = 0;
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        // Ready is raised only once the answer shows, so the slave must hold it.
        for (k = 0; k < 100 && !got; k++) begin
            @(posedge clk_in);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid && s_axi_bready) begin
                got = 1;
                s_axi_bready <= 0;
                chk({30'h0, s_axi_bresp}, {30'h0, er});
            end else if (s_axi_bvalid) begin
                s_axi_bready <= 1;
            end
        end
        if (!got) give_up();
    endtask
    task automatic rd(input logic [15:0] idx, input logic [7:0] ed, input logic [1:0] er);
        int k;
        logic got;
        got = 0;
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1;
        for (k = 0; k < 100 && !got; k++) begin
            @(posedge clk_in);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid && s_axi_rready) begin
                got = 1;
                s_axi_rready <= 0;
                chk(s_axi_rdata, {24'h000000, ed});
                chk({30'h0, s_axi_rresp}, {30'h0, er});
            end else if (s_axi_rvalid) begin
                s_axi_rready <= 1;
            end
        end
        if (!got) give_up();
    endtask
    // Slow RC edges, eight system cycles each, then time for the trip to land.
    task automatic rc_edges(input int n);
        repeat (n) begin
            lowspeed_rc_clk_in <= 1;
            repeat (4) @(posedge clk_in);
            lowspeed_rc_clk_in <= 0;
            repeat (4) @(posedge clk_in);
        end
        repeat (4) @(posedge clk_in);
    endtask

    // =========================================================================
    // Main sequence
    // =========================================================================
    initial begin
        repeat (20) @(posedge clk_in);
        rst_in <= 0;
        repeat (2) @(posedge clk_in);
        rd(WDT_CTRL_IDX, 8'h00, WDT_RESP_OKAY);
        wr(WDT_CTRL_IDX, 8'h1F, WDT_RESP_OKAY);
        rd(WDT_CTRL_IDX, 8'h1F, WDT_RESP_OKAY);
        rd(16'h0001, 8'h00, WDT_RESP_SLVERR);
        wr(WDT_CTRL_IDX, 8'h38, WDT_RESP_OKAY);
        chk({31'h0, rc_osc_request_out}, 32'h1);
        rc_edges(1023);
        chk(n_pulse, 0);
        rc_edges(1);
        chk(n_pulse, 1);
        rd(WDT_CTRL_IDX, 8'h98, WDT_RESP_OKAY);
        wr(WDT_CTRL_IDX, 8'h20, WDT_RESP_OKAY);
        wr(WDT_CTRL_IDX, 8'h00, WDT_RESP_OKAY);
        rd(WDT_CTRL_IDX, 8'h20, WDT_RESP_OKAY);
        rc_edges(1000);
        wr(WDT_SERVICE_IDX, WDT_SERVICE_KEY, WDT_RESP_OKAY);
        rc_edges(1000);
        chk(n_pulse, 1);
        rc_edges(24);
        chk(n_pulse, 2);
        rd(WDT_CTRL_IDX, 8'h80, WDT_RESP_OKAY);
        wr(WDT_OSC_IDX, 8'h01, WDT_RESP_OKAY);
        chk({31'h0, rc_osc_request_out}, 32'h1);
        wr(WDT_OSC_IDX, 8'h40, WDT_RESP_OKAY);
        wr(WDT_CTRL_IDX, 8'h60, WDT_RESP_OKAY);
        chk({31'h0, rc_osc_request_out}, 32'h0);
        wr(WDT_OSC_IDX, 8'h00, WDT_RESP_OKAY);
        repeat (4) @(posedge clk_in);
        chk(n_pulse, 3);
        rd(WDT_CTRL_IDX, 8'hC0, WDT_RESP_OKAY);
        wr(WDT_CTRL_IDX, 8'h28, WDT_RESP_OKAY);
        standby_in <= 1;
        repeat (4) @(posedge clk_in);
        standby_in <= 0;
        rd(WDT_CTRL_IDX, 8'h08, WDT_RESP_OKAY);
        chk({31'h0, rc_osc_request_out}, 32'h0);
        wr(WDT_CTRL_IDX, 8'h30, WDT_RESP_OKAY);
        standby_in <= 1;
        repeat (4) @(posedge clk_in);
        chk({31'h0, rc_osc_request_out}, 32'h0);
        standby_in <= 0;
        repeat (4) @(posedge clk_in);
        chk({31'h0, rc_osc_request_out}, 32'h1);
        external_reset_pin_n_in <= 0;
        repeat (8) @(posedge clk_in);
        external_reset_pin_n_in <= 1;
        repeat (4) @(posedge clk_in);
        rd(WDT_CTRL_IDX, 8'h00, WDT_RESP_OKAY);
        chk(n_pulse, 3);
        // Entering hold with the subclock selected must trip at once.
        wr(WDT_OSC_IDX, 8'h40, WDT_RESP_OKAY);
        wr(WDT_CTRL_IDX, 8'h60, WDT_RESP_OKAY);
        hold_in <= 1;
        repeat (4) @(posedge clk_in);
        chk(n_pulse, 4);
        rd(WDT_CTRL_IDX, 8'hC0, WDT_RESP_OKAY);
        results();
    end
endmodule

bind wdt_timer wdt_timer_chk u_chk (.clk_in, .rst_in, .external_reset_pin_n_in,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .wdt_reset_out);
